/* File: src/flp_pkg.sv */
/*
   flp_pkg: constants, timing counts and carrier types of the parallel flash
   host controller.
   assumes: one 125 MHz clock; device pins are registered by the controller.
*/
package flp_pkg;

   // clock rate and bus widths
   localparam int unsigned CLK_MHZ      = 125;
   localparam int unsigned ADDR_W       = 19;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned SECT_LSB     = 8;
   localparam int unsigned SECT_MSB     = 18;
   localparam int unsigned TOGGLE_BIT   = 6;
   localparam int unsigned SECTOR_BYTES = 256;
   localparam int unsigned CNT_W        = 9;
   localparam int unsigned TMR_W        = 8;
   localparam int unsigned LONG_W       = 24;

   // device timing in its own units
   localparam int unsigned T_ACC_NS     = 120;  // access time, worst grade
   localparam int unsigned T_AS_NS      = 10;   // address and gate setup
   localparam int unsigned T_WP_NS      = 90;   // write pulse width
   localparam int unsigned T_DH_NS      = 10;   // data hold
   localparam int unsigned T_WPH_NS     = 100;  // write pulse high
   localparam int unsigned GATE_HIGH_PULSE_MIN_NS    = 150;  // gate_high_pulse_min
   localparam int unsigned BYTE_LOAD_WINDOW_US     = 150;  // byte_load_window
   localparam int unsigned T_WC_MS      = 10;   // internal_program_period

   // least times round up, longest times round down
   localparam int unsigned ACC_CYC  = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned AS_CYC   = (T_AS_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WP_CYC   = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DH_CYC   = (T_DH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WPH_CYC  = (T_WPH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned OEHP_CYC = (GATE_HIGH_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned BLC_CYC  = BYTE_LOAD_WINDOW_US * CLK_MHZ;
   localparam int unsigned WC_CYC   = T_WC_MS * 1000 * CLK_MHZ;

   // user operations
   typedef enum logic [1:0]
   {
      OP_READ = 2'b00,
      OP_LOAD = 2'b01,
      OP_POLL = 2'b10,
      OP_NONE = 2'b11
   } flp_op_t;

   // answer codes
   typedef enum logic [1:0]
   {
      ERR_NONE    = 2'b00,
      ERR_SECTOR  = 2'b01,
      ERR_TIMEOUT = 2'b10,
      ERR_OP      = 2'b11
   } flp_err_t;

   typedef struct packed
   {
      flp_op_t             op;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } flp_req_t;

   typedef struct packed
   {
      logic                ce_n;
      logic                oe_n;
      logic                we_n;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   dq;
      logic                dq_oe;
   } flp_pins_t;

   localparam flp_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                       addr: '0, dq: '0, dq_oe: 1'b0};

endpackage

/* File: src/flp_timer.sv */
/*
   flp_timer: down counter that times one phase of a bus cycle.
   assumes: start is a one-cycle request; expired is read in the same domain.
*/
`timescale 1ns/1ps
`default_nettype none

module flp_timer
#(
   parameter int unsigned W = 8
)
(
   input  wire logic          mclk,
   input  wire logic          rst_n,
   input  wire logic          start,
   input  wire logic [W-1:0]  start_val,
   output logic               expired
);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;

   // load on start, else count down and rest at zero
   always_comb
   begin
      count_next = count_reg;
      if (start)
         count_next = start_val;
      else if (count_reg != '0)
         count_next = count_reg - 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         count_reg <= '0;
      else
         count_reg <= count_next;
   end

   assign expired = (count_reg == '0);

endmodule

`default_nettype wire

/* File: src/flp_host.sv */
/*
   flp_host: host-side controller for an asynchronous parallel flash with
   sector programming, software protection and toggle-bit status polling.
   assumes: device pins driven directly from these registers; dq_in is
   synchronous to mclk; command codes are supplied by the user as raw loads.

// Notes on behaviour
// - sector address bits stay the same for every byte load of one sector
// - output gate held high whenever write strobe and chip select are low
// - protection enable must be followed by a full 256-byte sector
// - protected writes: unlock code first, then sector address on each load
// - command words use data bits 7..0 and address bits 14..0
// - status reads pulse the gate, each high pulse meets its minimum
// - all status reads of one poll use one unchanged address
// - next load starts within 150 us of the last, else programming begins
*/
`timescale 1ns/1ps
`default_nettype none

module flp_host
#(
   parameter int unsigned BLC_CYC_P = flp_pkg::BLC_CYC,
   parameter int unsigned WC_CYC_P  = flp_pkg::WC_CYC
)
(
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   input  wire logic                          req_valid,
   input  wire flp_pkg::flp_req_t             req,
   output logic                               req_ready,
   output logic                               rsp_valid,
   output logic [flp_pkg::DATA_W-1:0]         rsp_data,
   output flp_pkg::flp_err_t                  rsp_err,
   output logic                               load_window_open,
   output logic [flp_pkg::CNT_W-1:0]          load_count,
   output logic                               sector_partial,
   output flp_pkg::flp_pins_t                 pins,
   input  wire logic [flp_pkg::DATA_W-1:0]    dq_in
);
   import flp_pkg::*;

   typedef enum logic [2:0]
   {
      ST_IDLE     = 3'b000,
      ST_RD_ACC   = 3'b001,
      ST_RD_GAP   = 3'b010,
      ST_LD_SET   = 3'b011,
      ST_LD_PULSE = 3'b100,
      ST_LD_HOLD  = 3'b101,
      ST_LD_GAP   = 3'b110
   } flp_state_t;

   localparam logic [LONG_W-1:0] BLC_LAST = LONG_W'(BLC_CYC_P - 1);
   localparam logic [LONG_W-1:0] WC_LIM   = LONG_W'(WC_CYC_P);
   localparam logic [CNT_W-1:0]  FULL_CNT = CNT_W'(SECTOR_BYTES);

   flp_state_t                state_reg,  state_next;
   flp_op_t                   op_reg,     op_next;
   logic [ADDR_W-1:0]         addr_reg,   addr_next;
   logic [DATA_W-1:0]         data_reg,   data_next;
   logic                      fin_reg,    fin_next;
   logic                      first_reg,  first_next;
   logic                      tog_reg,    tog_next;
   logic [LONG_W-1:0]         poll_reg,   poll_next;
   logic [LONG_W-1:0]         win_reg,    win_next;
   logic                      wopen_reg,  wopen_next;
   logic [CNT_W-1:0]          lcnt_reg,   lcnt_next;
   logic                      part_reg,   part_next;
   logic [SECT_MSB:SECT_LSB]  sect_reg,   sect_next;
   logic                      ready_reg,  ready_next;
   logic                      rv_reg,     rv_next;
   logic [DATA_W-1:0]         rd_reg,     rd_next;
   flp_err_t                  err_reg,    err_next;
   flp_pins_t                 pins_reg,   pins_next;
   logic                      tmr_start;
   logic [TMR_W-1:0]          tmr_val;
   logic                      tmr_done;

   // phase timer; every phase loads its cycle count minus one
   flp_timer #(.W(TMR_W)) u_timer
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .start     (tmr_start),
      .start_val (tmr_val),
      .expired   (tmr_done)
   );

   // sequencing, load window and status polling
   always_comb
   begin
      state_next = state_reg;
      op_next    = op_reg;
      addr_next  = addr_reg;
      data_next  = data_reg;
      fin_next   = fin_reg;
      first_next = first_reg;
      tog_next   = tog_reg;
      poll_next  = poll_reg;
      win_next   = win_reg;
      wopen_next = wopen_reg;
      lcnt_next  = lcnt_reg;
      part_next  = part_reg;
      sect_next  = sect_reg;
      rv_next    = 1'b0;
      rd_next    = rd_reg;
      err_next   = err_reg;
      tmr_start  = 1'b0;
      tmr_val    = '0;
      // polling gives up after one full program period
      if (op_reg == OP_POLL && state_reg != ST_IDLE && poll_reg != WC_LIM)
         poll_next = poll_reg + 1'b1;
      if (wopen_reg && win_reg == '0)
      begin
         wopen_next = 1'b0;
         // flag a period closed short of a full sector
         part_next  = (lcnt_reg != FULL_CNT);
      end
      else if (wopen_reg)
         win_next = win_reg - 1'b1;
      unique case (state_reg)
         ST_IDLE:
         begin
            if (req_valid && ready_reg)
            begin
               op_next    = req.op;
               // address captured once and held for the whole poll
               addr_next  = req.addr;
               data_next  = req.data;
               first_next = 1'b1;
               fin_next   = 1'b0;
               poll_next  = '0;
               unique case (req.op)
                  OP_READ, OP_POLL:
                  begin
                     state_next = ST_RD_ACC;
                     tmr_start  = 1'b1;
                     tmr_val    = TMR_W'(ACC_CYC - 1);
                  end
                  OP_LOAD:
                  begin
                     // refuse a sector change inside an open period
                     if (wopen_reg && req.addr[SECT_MSB:SECT_LSB] != sect_reg)
                     begin
                        rv_next  = 1'b1;
                        err_next = ERR_SECTOR;
                     end
                     else
                     begin
                        state_next = ST_LD_SET;
                        tmr_start  = 1'b1;
                        tmr_val    = TMR_W'(AS_CYC - 1);
                     end
                  end
                  OP_NONE:
                  begin
                     rv_next  = 1'b1;
                     err_next = ERR_OP;
                  end
               endcase
            end
         end
         ST_RD_ACC:
         begin
            if (tmr_done)
            begin
               state_next = ST_RD_GAP;
               tmr_start  = 1'b1;
               tmr_val    = TMR_W'(OEHP_CYC - 1);
               rd_next    = dq_in;
               first_next = 1'b0;
               tog_next   = dq_in[TOGGLE_BIT];
               if (op_reg == OP_READ)
               begin
                  fin_next = 1'b1;
                  rv_next  = 1'b1;
                  err_next = ERR_NONE;
               end
               // two equal reads of bit 6 mean programming is over
               else if (!first_reg && dq_in[TOGGLE_BIT] == tog_reg)
               begin
                  fin_next = 1'b1;
                  rv_next  = 1'b1;
                  err_next = ERR_NONE;
               end
               else if (poll_reg == WC_LIM)
               begin
                  fin_next = 1'b1;
                  rv_next  = 1'b1;
                  err_next = ERR_TIMEOUT;
               end
            end
         end
         ST_RD_GAP:
         begin
            // gate high for its minimum pulse before the next read
            if (tmr_done)
            begin
               if (fin_reg)
                  state_next = ST_IDLE;
               else
               begin
                  state_next = ST_RD_ACC;
                  tmr_start  = 1'b1;
                  tmr_val    = TMR_W'(ACC_CYC - 1);
               end
            end
         end
         ST_LD_SET:
         begin
            if (tmr_done)
            begin
               state_next = ST_LD_PULSE;
               tmr_start  = 1'b1;
               tmr_val    = TMR_W'(WP_CYC - 1);
            end
         end
         ST_LD_PULSE:
         begin
            if (tmr_done)
            begin
               state_next = ST_LD_HOLD;
               tmr_start  = 1'b1;
               tmr_val    = TMR_W'(DH_CYC - 1);
               // window restarts at the strobe's rising edge
               wopen_next = 1'b1;
               win_next   = BLC_LAST;
               // a short flag raised by a lapse in this same cycle wins over the clear
               if (!(wopen_reg && win_reg == '0))
                  part_next = 1'b0;
               if (wopen_reg && win_reg != '0)
                  lcnt_next = lcnt_reg + 1'b1;
               else
               begin
                  lcnt_next = CNT_W'(1);
                  sect_next = addr_reg[SECT_MSB:SECT_LSB];
               end
            end
         end
         ST_LD_HOLD:
         begin
            if (tmr_done)
            begin
               state_next = ST_LD_GAP;
               tmr_start  = 1'b1;
               tmr_val    = TMR_W'(WPH_CYC - 1);
            end
         end
         ST_LD_GAP:
         begin
            if (tmr_done)
            begin
               state_next = ST_IDLE;
               rv_next    = 1'b1;
               err_next   = ERR_NONE;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
      ready_next = (state_next == ST_IDLE);
   end

   // pin levels follow the state being entered
   always_comb
   begin
      pins_next      = PINS_IDLE;
      pins_next.addr = addr_next;
      pins_next.dq   = data_next;
      unique case (state_next)
         ST_IDLE:
         begin
            pins_next.addr = addr_reg;
         end
         ST_RD_ACC:
         begin
            pins_next.ce_n = 1'b0;
            pins_next.oe_n = 1'b0;
         end
         ST_RD_GAP:
         begin
            // polls toggle only the gate, chip select stays low until the last read
            pins_next.ce_n = fin_next;
         end
         ST_LD_SET, ST_LD_HOLD:
         begin
            pins_next.ce_n  = 1'b0;
            pins_next.dq_oe = 1'b1;
         end
         ST_LD_PULSE:
         begin
            // gate stays high while both strobes are low
            pins_next.ce_n  = 1'b0;
            pins_next.we_n  = 1'b0;
            pins_next.dq_oe = 1'b1;
         end
         ST_LD_GAP:
         begin
            pins_next.ce_n = 1'b1;
         end
         default:
         begin
            pins_next = PINS_IDLE;
         end
      endcase
   end

   // state registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         op_reg    <= OP_NONE;
         addr_reg  <= '0;
         data_reg  <= '0;
         fin_reg   <= 1'b0;
         first_reg <= 1'b1;
         tog_reg   <= 1'b0;
         poll_reg  <= '0;
         win_reg   <= '0;
         wopen_reg <= 1'b0;
         lcnt_reg  <= '0;
         part_reg  <= 1'b0;
         sect_reg  <= '0;
         ready_reg <= 1'b0;
         rv_reg    <= 1'b0;
         rd_reg    <= '0;
         err_reg   <= ERR_NONE;
         pins_reg  <= PINS_IDLE;
      end
      else
      begin
         state_reg <= state_next;
         op_reg    <= op_next;
         addr_reg  <= addr_next;
         data_reg  <= data_next;
         fin_reg   <= fin_next;
         first_reg <= first_next;
         tog_reg   <= tog_next;
         poll_reg  <= poll_next;
         win_reg   <= win_next;
         wopen_reg <= wopen_next;
         lcnt_reg  <= lcnt_next;
         part_reg  <= part_next;
         sect_reg  <= sect_next;
         ready_reg <= ready_next;
         rv_reg    <= rv_next;
         rd_reg    <= rd_next;
         err_reg   <= err_next;
         pins_reg  <= pins_next;
      end
   end

   // command words leave as raw address and data loads
   assign pins             = pins_reg;
   assign req_ready        = ready_reg;
   assign rsp_valid        = rv_reg;
   assign rsp_data         = rd_reg;
   assign rsp_err          = err_reg;
   assign load_window_open = wopen_reg;
   assign load_count       = lcnt_reg;
   assign sector_partial   = part_reg;

endmodule

`default_nettype wire

/* File: bench/flp_flash_model.sv */
/*
   flp_flash_model: behavioural parallel flash as seen from its pins.
   assumes: pins come from flp_host and are sampled on mclk; no protect mode.
*/
`timescale 1ns/1ps
`default_nettype none

module flp_flash_model
#(
   parameter int unsigned BLC = 200,
   parameter int unsigned WC  = 300,
   parameter logic [18:0] CMD_A    = 19'h05555,
   parameter logic [7:0]  ID_ON    = 8'hAA,
   parameter logic [7:0]  ID_OFF   = 8'h55,
   parameter logic [7:0]  MAKER_ID = 8'h5C,  // arbitrary value
   parameter logic [7:0]  PART_ID  = 8'h3B   // arbitrary value
)
(
   input  wire logic                   mclk,
   input  wire flp_pkg::flp_pins_t     pins,
   input  wire logic                   slow,
   output logic [flp_pkg::DATA_W-1:0]  dq_in
);
   import flp_pkg::*;
   logic [7:0]   mem [logic [18:0]];
   logic [7:0]   buff [256];
   logic [255:0] got = '0;
   logic [10:0]  sect;
   logic [18:0]  last_a;
   logic [7:0]   last_d;
   logic         we_d = 1'b1;
   logic         oe_d = 1'b1;
   logic         tgl = 1'b0;
   logic         busy = 1'b0;
   logic         loading = 1'b0;
   // comes up in array read, never in id mode
   logic         idm = 1'b0;
   int unsigned  win = 0;
   int unsigned  prog = 0;

   // one device step per clock; slow stretches programming to eight times WC
   always @(posedge mclk)
   begin
      we_d <= pins.we_n;
      oe_d <= pins.oe_n;
      // each strobe release latches a byte and restarts the window
      if (pins.we_n && !we_d && !pins.ce_n)
      begin
         got = loading ? got : '0;
         got[pins.addr[7:0]] = 1'b1;
         buff[pins.addr[7:0]] = pins.dq;
         sect = pins.addr[18:8];
         last_a <= pins.addr;
         last_d <= pins.dq;
         loading <= 1'b1;
         win <= BLC;
         // id mode entered and left by command loads
         if (pins.addr == CMD_A && pins.dq == ID_ON)
            idm <= 1'b1;
         else if (pins.addr == CMD_A && pins.dq == ID_OFF)
            idm <= 1'b0;
      end
      else if (loading && win != 0)
         win <= win - 1;
      // a lapse starts programming; bytes not loaded come out scrambled
      else if (loading)
      begin
         for (int i = 0; i < 256; i++)
            mem[{sect, 8'(i)}] = got[i] ? buff[i] : 8'(i * 37);
         loading <= 1'b0;
         busy <= 1'b1;
         prog <= slow ? WC * 8 : WC;
      end
      else if (busy)
      begin
         busy <= (prog > 1);
         prog <= prog - 1;
      end
      // status bit flips at every gate fall while programming
      if (busy && !pins.oe_n && oe_d)
         tgl <= ~tgl;
      // status while busy, id codes or array after; released bus shows junk
      if (!pins.ce_n && !pins.oe_n)
         dq_in <= busy ? {1'b1, tgl, 6'h15}
                : (idm && pins.addr[18:1] == '0) ? (pins.addr[0] ? PART_ID : MAKER_ID)
                : (mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF);
      else
         dq_in <= ~dq_in;
   end
endmodule

`default_nettype wire

/* File: bench/flp_host_checker.sv */
/*
   flp_host_checker: assertions on the flash host controller ports.
   assumes: bound into flp_host; single clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module flp_host_checker
#(
   parameter int unsigned BLC_CYC_P = 200
)
(
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   input  wire logic                       req_valid,
   input  wire flp_pkg::flp_req_t          req,
   input  wire logic                       req_ready,
   input  wire logic                       rsp_valid,
   input  wire flp_pkg::flp_err_t          rsp_err,
   input  wire logic                       load_window_open,
   input  wire logic [flp_pkg::CNT_W-1:0]  load_count,
   input  wire logic                       sector_partial,
   input  wire flp_pkg::flp_pins_t         pins
);
   import flp_pkg::*;
   logic [7:0]  hi_reg, hi_next;
   logic [15:0] age_reg, age_next;
   logic [10:0] sect_reg, sect_next;

   // gate high time, time since strobe low, sector of the last strobe
   always_comb
   begin
      hi_next = pins.oe_n ? hi_reg + 8'(hi_reg != 8'hFF) : 8'h00;
      age_next = pins.we_n ? age_reg + 16'(age_reg != 16'hFFFF) : 16'h0000;
      sect_next = pins.we_n ? sect_reg : pins.addr[18:8];
   end

   // counters start saturated so nothing fires before the first access
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hi_reg <= 8'hFF;
         age_reg <= 16'hFFFF;
         sect_reg <= 11'h000;
      end
      else
      begin
         hi_reg <= hi_next;
         age_reg <= age_next;
         sect_reg <= sect_next;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_gate_off_write;
      !pins.ce_n && !pins.we_n |-> pins.oe_n;
   endproperty
   a_gate_off_write: assert property (p_gate_off_write)
      else $error("gate low during a write");
   property p_no_contend;
      pins.dq_oe |-> pins.oe_n;
   endproperty
   a_no_contend: assert property (p_no_contend)
      else $error("data driven while gate low");
   property p_gate_pulse;
      $fell(pins.oe_n) |-> hi_reg >= OEHP_CYC;
   endproperty
   a_gate_pulse: assert property (p_gate_pulse)
      else $error("gate high pulse too short");
   property p_addr_hold;
      !pins.ce_n && $past(!pins.ce_n) |-> $stable(pins.addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved while selected");
   property p_strobe_width;
      $fell(pins.we_n) |-> (!pins.we_n && !pins.ce_n) throughout (##11 1'b1);
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("write strobe too short");
   property p_window_opens;
      $rose(pins.we_n) |-> ##[0:1] load_window_open;
   endproperty
   a_window_opens: assert property (p_window_opens)
      else $error("load window did not open");
   property p_window_len;
      load_window_open |-> age_reg <= 16'(BLC_CYC_P + 4);
   endproperty
   a_window_len: assert property (p_window_len)
      else $error("load window outlived its limit");
   property p_short_flag;
      $fell(load_window_open) && load_count != 9'h100 |-> ##[0:2] sector_partial;
   endproperty
   a_short_flag: assert property (p_short_flag)
      else $error("short sector not flagged");
   property p_sector_refuse;
      req_valid && req_ready && req.op == OP_LOAD && load_window_open
         && req.addr[18:8] != sect_reg |-> ##[1:2] rsp_valid && rsp_err == ERR_SECTOR;
   endproperty
   a_sector_refuse: assert property (p_sector_refuse)
      else $error("foreign sector load not refused");
   property p_read_time;
      req_valid && req_ready && req.op == OP_READ |-> ##16 rsp_valid;
   endproperty
   a_read_time: assert property (p_read_time)
      else $error("read answer late or early");

   c_load: cover property ($rose(load_window_open));
   c_poll: cover property (req_valid && req_ready && req.op == OP_POLL);
   c_refuse: cover property (rsp_valid && rsp_err == ERR_SECTOR);
endmodule

bind flp_host flp_host_checker #(.BLC_CYC_P(BLC_CYC_P)) i_flp_host_checker (.mclk, .rst_n,
   .req_valid, .req, .req_ready, .rsp_valid, .rsp_err, .load_window_open, .load_count,
   .sector_partial, .pins);

`default_nettype wire

/* File: bench/flp_host_tb.sv */
/*
   flp_host_tb: self-checking bench for the flash host controller.
   assumes: flp_flash_model stands in for the device; the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t ns: %s", $time, m); end end

module flp_host_tb;
   import flp_pkg::*;
   logic                mclk = 1'b0;
   logic                rst_n, req_valid, req_ready, rsp_valid, slow;
   logic                load_window_open, sector_partial;
   flp_req_t            req;
   flp_pins_t           pins;
   flp_err_t            rsp_err, er;
   logic [DATA_W-1:0]   rsp_data, dq_in, rd;
   logic [CNT_W-1:0]    load_count;
   logic [7:0]          probe [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
   int                  errors, compares;

   flp_host #(.BLC_CYC_P(200), .WC_CYC_P(500)) i_flp_host (.mclk, .rst_n, .req_valid,
      .req, .req_ready, .rsp_valid, .rsp_data, .rsp_err, .load_window_open,
      .load_count, .sector_partial, .pins, .dq_in);
   flp_flash_model #(.BLC(200), .WC(300)) i_flp_flash_model (.mclk, .pins, .slow, .dq_in);

   // 125 MHz clock
   always #4 mclk = ~mclk;

   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // request held until taken, then answer awaited under a bound
   task automatic do_req(input flp_op_t op, input logic [18:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req = '{op: op, addr: a, data: d};
      req_valid = 1'b1;
      do @(posedge mclk); while (req_ready !== 1'b1 && ++n < 100);
      #1;
      req_valid = 1'b0;
      // a refusal answers right after the take, so look before the next edge
      while (rsp_valid !== 1'b1 && ++n < 2000)
      begin
         @(posedge mclk);
         #1;
      end
      if (rsp_valid !== 1'b1)
      begin
         errors++;
         report_and_stop();
      end
      rd = rsp_data;
      er = rsp_err;
      // one edge between requests so valid never rises where it just fell
      @(posedge mclk);
      #1;
   endtask

   // waits for both sides to close the load period, and optionally to finish programming
   task automatic wait_close(input bit idle);
      int n;
      n = 0;
      while ((load_window_open !== 1'b0 || i_flp_flash_model.loading
             || (idle && i_flp_flash_model.busy)) && n++ < 5000)
      begin
         @(posedge mclk);
         #1;
      end
      if (n > 5000)
      begin
         errors++;
         report_and_stop();
      end
   endtask

   // hang guard
   initial
   begin
      repeat (100000) @(posedge mclk);
      errors++;
      report_and_stop();
   end

   initial
   begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      slow = 1'b0;
      req = '0;
      errors = 0;
      compares = 0;
      repeat (12) @(posedge mclk);
      #1;
      `CHK(pins, PINS_IDLE, "pins not idle in reset")
      rst_n = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      // full sector back to back, with a foreign sector slipped in mid-way
      for (int i = 0; i < 256; i++)
      begin
         do_req(OP_LOAD, {11'h003, 8'(i)}, 8'(i) ^ 8'hC3);
         `CHK(er, ERR_NONE, "load refused")
         if (i == 128)
         begin
            do_req(OP_LOAD, 19'h00400, 8'h00);
            `CHK(er, ERR_SECTOR, "foreign sector taken")
         end
      end
      `CHK(load_count, 9'h100, "sector count")
      wait_close(0);
      `CHK(sector_partial, 1'b0, "full sector flagged short")
      do_req(OP_POLL, 19'h00300, 8'h00);
      `CHK(er, ERR_NONE, "poll did not settle")
      foreach (probe[k])
      begin
         do_req(OP_READ, {11'h003, probe[k]}, 8'h00);
         `CHK(rd, probe[k] ^ 8'hC3, "array byte after program")
      end
      $display("test full sector done");
      // command word stays on the low address and data bits
      do_req(OP_LOAD, 19'h05555, 8'hAA);
      `CHK({i_flp_flash_model.last_a, i_flp_flash_model.last_d}, 27'h05555AA, "cmd word")
      wait_close(1);
      do_req(OP_READ, 19'h00000, 8'h00);
      `CHK(rd, i_flp_flash_model.MAKER_ID, "maker code")
      do_req(OP_READ, 19'h00001, 8'h00);
      `CHK(rd, i_flp_flash_model.PART_ID, "part code")
      do_req(OP_LOAD, 19'h05555, 8'h55);
      wait_close(1);
      do_req(OP_READ, 19'h00300, 8'h00);
      `CHK(rd, 8'hC3, "array read after id exit")
      $display("test command word done");
      // short sector: flagged, second loaded byte kept
      do_req(OP_LOAD, 19'h00500, 8'h11);
      do_req(OP_LOAD, 19'h00501, 8'h22);
      wait_close(0);
      `CHK({sector_partial, load_count}, {1'b1, 9'h002}, "short sector")
      do_req(OP_POLL, 19'h00500, 8'h00);
      do_req(OP_READ, 19'h00501, 8'h00);
      `CHK(rd, 8'h22, "loaded byte lost")
      $display("test short sector done");
      // program that never ends within the poll limit
      slow = 1'b1;
      do_req(OP_LOAD, 19'h00600, 8'h33);
      wait_close(0);
      do_req(OP_POLL, 19'h00600, 8'h00);
      `CHK(er, ERR_TIMEOUT, "endless program not reported")
      slow = 1'b0;
      wait_close(1);
      do_req(OP_LOAD, 19'h00700, 8'h44);
      `CHK({sector_partial, load_count}, {1'b0, 9'h001}, "new period count")
      $display("test poll timeout done");
      report_and_stop();
   end
endmodule

`default_nettype wire
